// ===== rtl/ihc_ctrl.sv
// Interrupt flag exceptions and halt control with an AHB-Lite slave.
// Function
// - Level mode: ext0 request follows pin directly
// - Edge to level switch clears edge latch
// - Level to edge keeps flag; rewrite clears
// - Capture flag clears when FIFO fully read
// - Writing capture reset bit clears capture flag
// - Generator FIFO write clears generator flag
// - Serial flag clears only by reset, read
// - Serial flag register read clears all bits
// - Shared channel source change clears flag
// - HALT enters RUN or STOP per bit
// - RUN halt stops only instruction execution
// - STOP halt suspends oscillator and circuits
// - Interrupt or reset releases RUN; only ext0 or reset releases STOP
// - Disabled release resumes, flag stays set
// - Pending request makes HALT end immediately
// - Reset release clears state; prefer ext0
// - STOP release waits for warm-up counter
// - Vector code write clears channel latch, serial excepted
`include "ihc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module ihc_ctrl #(
    parameter int unsigned WARMUP_CYCLES = `IHC_WARMUP_CYCLES
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        ext0_pin,
    input  wire logic        capture_set,
    input  wire logic        capture_fifo_drained,
    input  wire logic        gen_set,
    input  wire logic        gen_fifo_write,
    input  wire logic        serial_ch0_set,
    input  wire logic        serial_ch1_set,
    input  wire logic        serial_rx_read,
    input  wire logic        vass_set,
    input  wire logic        ext_irq_two_set,
    input  wire logic        halt_exec,
    input  wire logic        cpu_irq_enable_flag,
    input  wire logic        irq_ack,
    input  wire logic [1:0]  irq_ack_chan,
    output logic             cpu_irq_req,
    output logic             cpu_exec_stop,
    output logic             osc_stop,
    output logic             sys_clk_hold,
    output logic             pin_drive_en
);
    // ================================================================
    // Bus slave
    // ================================================================
    function automatic logic reg_hit(input logic [15:0] idx,
                                     input logic [15:0] want);
        reg_hit = (idx == want);
    endfunction : reg_hit

    ihc_pkg::ihc_dphase_s dp_ff;
    logic [31:0]          hrdata_ff;
    logic                 aphase;
    logic [15:0]          ap_idx;
    logic                 ap_rd;
    logic                 wr_now;
    logic [7:0]           wd;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_ff;
    assign aphase    = hsel && htrans[1] && hready;
    assign ap_idx    = haddr[17:2];
    assign ap_rd     = aphase && !hwrite && (haddr[31:18] == 14'h0000);
    assign wr_now    = dp_ff.wr;
    assign wd        = hwdata[7:0];

    // ================================================================
    // Register state and flags
    // ================================================================
    logic [7:0]          ext0_mode_ff;
    logic [7:0]          halt_mode_ff;
    logic [3:0]          irq_en_ff;
    logic                src_sel_ff;
    logic                cap_from_gen_ff;
    logic                ext0_latch_ff;
    logic                cap_flag_ff;
    logic                sio_flag_ff;
    logic [1:0]          sio_ch_ff;
    logic                vass_flag_ff;
    ihc_pkg::ihc_halt_e  halt_ff;
    ihc_pkg::ihc_halt_e  nxt_halt;
    ihc_pkg::ihc_req_s   req;

    logic wr_ext0;
    logic wr_halt;
    logic wr_en;
    logic wr_src;
    logic wr_vclr;
    logic wr_servo;
    logic rd_sio;
    logic ext0_edge;
    logic new_edge;
    logic ext0_lvl;
    logic ext0_prev_ff;
    logic ext0_rise;
    logic ext0_load;
    logic ext0_clr;
    logic cap_clr;
    logic sio_set;
    logic sio_clr;
    logic vass_in;
    logic vass_clr;
    logic src_change;
    logic wake;
    logic stop_wake;
    logic warm_start;
    logic warm_done;
    logic ack_ext0;
    logic ack_cap;
    logic ack_vass;
    logic [31:0] rd_mux;

    assign wr_ext0  = wr_now && reg_hit(dp_ff.idx, `IHC_IDX_EXT0_MODE);
    assign wr_halt  = wr_now && reg_hit(dp_ff.idx, `IHC_IDX_HALT_MODE);
    assign wr_en    = wr_now && reg_hit(dp_ff.idx, `IHC_IDX_IRQ_EN);
    assign wr_src   = wr_now && reg_hit(dp_ff.idx, `IHC_IDX_SRC_SEL);
    assign wr_vclr  = wr_now && reg_hit(dp_ff.idx, `IHC_IDX_VEC_CLR);
    assign wr_servo = wr_now && reg_hit(dp_ff.idx, `IHC_IDX_SERVO_FLAG);
    assign rd_sio   = ap_rd && reg_hit(ap_idx, `IHC_IDX_SIO_FLAG);

    assign ack_ext0 = irq_ack && (irq_ack_chan == 2'd0);
    assign ack_cap  = irq_ack && (irq_ack_chan == 2'd1);
    assign ack_vass = irq_ack && (irq_ack_chan == 2'd3);

    // ================================================================
    // External interrupt 0
    // ================================================================
    ihc_sync2 u_ext0_sync (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .async_in (ext0_pin),
        .sync_out (ext0_lvl)
    );

    assign ext0_edge = ext0_mode_ff[`IHC_EXT0_EDGE_BIT];
    assign new_edge  = wd[`IHC_EXT0_EDGE_BIT];
    assign ext0_rise = ext0_edge && ext0_lvl && !ext0_prev_ff;
    // A level-accepted request survives the switch to edge mode.
    assign ext0_load = wr_ext0 && !ext0_edge && new_edge;
    // Any write to the mode register in edge mode drops the latch.
    assign ext0_clr  = (wr_ext0 && ext0_edge)
                    || ack_ext0
                    || (wr_vclr && wd == `IHC_VCODE_EXT0);
    assign req.ext0  = ext0_edge ? ext0_latch_ff : ext0_lvl;

    // ================================================================
    // Other channels
    // ================================================================
    assign cap_clr  = (!cap_from_gen_ff && capture_fifo_drained)
                   || (wr_servo && wd[`IHC_CAP_RESET_BIT])
                   || (cap_from_gen_ff && gen_fifo_write)
                   || ack_cap
                   || (wr_vclr && wd == `IHC_VCODE_CAP);
    assign req.cap  = cap_flag_ff;

    // The serial flag ignores the vector clear and acceptance on purpose.
    assign sio_set  = serial_ch0_set || serial_ch1_set;
    assign sio_clr  = serial_rx_read || rd_sio;
    assign req.sio  = sio_flag_ff;

    assign src_change = wr_src && (wd[`IHC_SRC_SEL_BIT] != src_sel_ff);
    assign vass_in  = src_sel_ff ? ext_irq_two_set : vass_set;
    assign vass_clr = src_change
                   || ack_vass
                   || (wr_vclr && wd == `IHC_VCODE_VASS);
    assign req.vass = vass_flag_ff;

    // ================================================================
    // Halt control
    // ================================================================
    assign wake        = |(req & irq_en_ff);
    assign stop_wake   = req.ext0 && irq_en_ff[0];
    assign cpu_irq_req = wake && cpu_irq_enable_flag;
    assign warm_start  = (halt_ff == ihc_pkg::IHC_HALT_STOP) && stop_wake;

    ihc_warmup #(
        .CYCLES (WARMUP_CYCLES)
    ) u_warmup (
        .sys_clk (sys_clk),
        .rst     (rst),
        .start   (warm_start),
        .done    (warm_done)
    );

    always_comb
    begin
        nxt_halt = halt_ff;
        unique case (halt_ff)
            ihc_pkg::IHC_ACTIVE:
                // A latched enabled request lets HALT fall straight through.
                if (halt_exec && !wake)
                    nxt_halt = halt_mode_ff[`IHC_HALT_STOP_BIT]
                             ? ihc_pkg::IHC_HALT_STOP
                             : ihc_pkg::IHC_HALT_RUN;
            ihc_pkg::IHC_HALT_RUN:
                if (wake)
                    nxt_halt = ihc_pkg::IHC_ACTIVE;
            ihc_pkg::IHC_HALT_STOP:
                if (stop_wake)
                    nxt_halt = ihc_pkg::IHC_WARMUP;
            ihc_pkg::IHC_WARMUP:
                if (warm_done)
                    nxt_halt = ihc_pkg::IHC_ACTIVE;
        endcase
    end

    assign cpu_exec_stop = (halt_ff != ihc_pkg::IHC_ACTIVE);
    assign osc_stop      = (halt_ff == ihc_pkg::IHC_HALT_STOP);
    assign sys_clk_hold  = (halt_ff == ihc_pkg::IHC_HALT_STOP)
                        || (halt_ff == ihc_pkg::IHC_WARMUP);
    assign pin_drive_en  = halt_mode_ff[`IHC_DRIVE_EN_BIT];

    // ================================================================
    // Read data
    // ================================================================
    assign rd_mux =
        reg_hit(ap_idx, `IHC_IDX_EXT0_MODE) ? {24'h000000, ext0_mode_ff} :
        reg_hit(ap_idx, `IHC_IDX_HALT_MODE) ? {24'h000000, halt_mode_ff} :
        reg_hit(ap_idx, `IHC_IDX_IRQ_EN)    ? {28'h0000000, irq_en_ff} :
        reg_hit(ap_idx, `IHC_IDX_SRC_SEL)   ?
            {28'h0000000, src_sel_ff, 3'h0} :
        reg_hit(ap_idx, `IHC_IDX_REQ_STAT)  ? {28'h0000000, req} :
        reg_hit(ap_idx, `IHC_IDX_SIO_FLAG)  ?
            {29'h00000000, sio_flag_ff, sio_ch_ff} :
        reg_hit(ap_idx, `IHC_IDX_HALT_STAT) ? {30'h00000000, halt_ff} :
        32'h00000000;

    // ================================================================
    // Registers
    // ================================================================
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            dp_ff     <= '0;
            hrdata_ff <= 32'h00000000;
        end
        else
        begin
            dp_ff.wr  <= aphase && hwrite && (haddr[31:18] == 14'h0000);
            dp_ff.idx <= ap_idx;
            if (ap_rd)
                hrdata_ff <= rd_mux;
        end
    end

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ext0_mode_ff <= `IHC_RST_BYTE;
            halt_mode_ff <= `IHC_RST_BYTE;
            irq_en_ff    <= `IHC_RST_NIBBLE;
            src_sel_ff   <= 1'b0;
        end
        else
        begin
            if (wr_ext0)
                ext0_mode_ff <= wd;
            if (wr_halt)
                halt_mode_ff <= wd;
            if (wr_en)
                irq_en_ff <= wd[3:0];
            if (wr_src)
                src_sel_ff <= wd[`IHC_SRC_SEL_BIT];
        end
    end

    // Every flag below lets a set in the same cycle win over its clear.
    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ext0_prev_ff    <= 1'b0;
            ext0_latch_ff   <= 1'b0;
            cap_flag_ff     <= 1'b0;
            cap_from_gen_ff <= 1'b0;
            sio_flag_ff     <= 1'b0;
            sio_ch_ff       <= 2'b00;
            vass_flag_ff    <= 1'b0;
            halt_ff         <= ihc_pkg::IHC_ACTIVE;
        end
        else
        begin
            ext0_prev_ff  <= ext0_lvl;
            ext0_latch_ff <= ext0_load ? ext0_lvl
                           : (ext0_rise || (ext0_latch_ff && !ext0_clr));
            cap_flag_ff   <= capture_set || gen_set
                          || (cap_flag_ff && !cap_clr);
            if (capture_set || gen_set)
                cap_from_gen_ff <= gen_set && !capture_set;
            sio_flag_ff   <= sio_set || (sio_flag_ff && !sio_clr);
            sio_ch_ff     <= {serial_ch1_set, serial_ch0_set}
                          | (rd_sio ? 2'b00 : sio_ch_ff);
            vass_flag_ff  <= vass_in || (vass_flag_ff && !vass_clr);
            halt_ff       <= nxt_halt;
        end
    end

    // ================================================================
    // Checks
    // ================================================================
    a_ext0_level_follow: assert property (
        @(posedge sys_clk) disable iff (rst)
        !ext0_edge |-> (req.ext0 == ext0_lvl))
        else $error("ext0 level request does not follow the pin");

    a_edge_level_clear: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_ext0 && ext0_edge && !new_edge |=> !ext0_latch_ff [*2])
        else $error("edge latch survived switch to level mode");

    a_level_edge_keep: assert property (
        @(posedge sys_clk) disable iff (rst)
        ext0_load && ext0_lvl |=> ext0_edge && req.ext0)
        else $error("level request lost on switch to edge mode");

    a_edge_rise_latch: assert property (
        @(posedge sys_clk) disable iff (rst)
        ext0_edge && !wr_ext0 && $rose(ext0_lvl) |=> ext0_latch_ff)
        else $error("rising edge not latched in edge mode");

    a_cap_reset_clear: assert property (
        @(posedge sys_clk) disable iff (rst)
        wr_servo && wd[`IHC_CAP_RESET_BIT] && !capture_set && !gen_set
        |=> !cap_flag_ff)
        else $error("capture flag not cleared by reset bit");

    a_gen_fifo_clear: assert property (
        @(posedge sys_clk) disable iff (rst)
        cap_flag_ff && cap_from_gen_ff && gen_fifo_write
        && !capture_set && !gen_set |=> !cap_flag_ff)
        else $error("generator flag not cleared by FIFO write");

    a_sio_vclr_ignored: assert property (
        @(posedge sys_clk) disable iff (rst)
        sio_flag_ff && !serial_rx_read && !rd_sio |=> sio_flag_ff)
        else $error("serial flag cleared by a foreign source");

    a_sio_read_clear: assert property (
        @(posedge sys_clk) disable iff (rst)
        rd_sio && !sio_set |=> !sio_flag_ff && sio_ch_ff == 2'b00
        && hrdata[`IHC_SIO_REQ_BIT:0] == $past({sio_flag_ff, sio_ch_ff}))
        else $error("serial flag register read did not clear");

    a_src_change_clear: assert property (
        @(posedge sys_clk) disable iff (rst)
        src_change && !vass_in |=> !vass_flag_ff)
        else $error("shared channel flag kept after source change");

    a_halt_mode_select: assert property (
        @(posedge sys_clk) disable iff (rst)
        halt_ff == ihc_pkg::IHC_ACTIVE && halt_exec && !wake
        |=> osc_stop == $past(halt_mode_ff[`IHC_HALT_STOP_BIT])
            && cpu_exec_stop)
        else $error("HALT entered the wrong mode");

    a_halt_fall_through: assert property (
        @(posedge sys_clk) disable iff (rst)
        halt_ff == ihc_pkg::IHC_ACTIVE && halt_exec && wake
        |=> !cpu_exec_stop)
        else $error("HALT entered with a request pending");

    a_stop_warmup_hold: assert property (
        @(posedge sys_clk) disable iff (rst)
        warm_start |=> sys_clk_hold && !osc_stop)
        else $error("clock released before warm-up");

endmodule : ihc_ctrl
`default_nettype wire

// ===== rtl/ihc_defines.svh
// Register indices, bit positions, reset values and counts of the block.
`ifndef IHC_DEFINES_SVH
`define IHC_DEFINES_SVH

// Register indices; the byte address on the bus is four times the index.
`define IHC_IDX_EXT0_MODE  16'hFFC7
`define IHC_IDX_HALT_MODE  16'hFFE6
`define IHC_IDX_IRQ_EN     16'hFFE9
`define IHC_IDX_SRC_SEL    16'hFFEA
`define IHC_IDX_REQ_STAT   16'hFFEC
`define IHC_IDX_VEC_CLR    16'hFFED
`define IHC_IDX_SIO_FLAG   16'hFFF0
`define IHC_IDX_SERVO_FLAG 16'hFFF1
`define IHC_IDX_HALT_STAT  16'hFFF2

// Field positions.
`define IHC_EXT0_EDGE_BIT  5
`define IHC_HALT_STOP_BIT  2
`define IHC_DRIVE_EN_BIT   0
`define IHC_SRC_SEL_BIT    3
`define IHC_CAP_RESET_BIT  0
`define IHC_SIO_REQ_BIT    2

// Vector codes (vector value divided by eight) of the four channels.
`define IHC_VCODE_EXT0     8'h01
`define IHC_VCODE_SIO      8'h05
`define IHC_VCODE_CAP      8'h06
`define IHC_VCODE_VASS     8'h07

// Reset values.
`define IHC_RST_BYTE       8'h00
`define IHC_RST_NIBBLE     4'h0

// Oscillator warm-up after leaving STOP, in oscillator cycles.
`define IHC_WARMUP_CYCLES  1048576

`endif

// ===== rtl/ihc_pkg.sv
// Types shared by the interrupt exception and halt control block.
package ihc_pkg;

    typedef enum logic [1:0] {
        IHC_ACTIVE    = 2'b00,
        IHC_HALT_RUN  = 2'b01,
        IHC_HALT_STOP = 2'b10,
        IHC_WARMUP    = 2'b11
    } ihc_halt_e;

    typedef struct packed {
        logic vass;
        logic sio;
        logic cap;
        logic ext0;
    } ihc_req_s;

    typedef struct packed {
        logic        wr;
        logic [15:0] idx;
    } ihc_dphase_s;

endpackage : ihc_pkg

// ===== rtl/ihc_sync2.sv
// Two-flop synchroniser for an asynchronous pin.
`timescale 1ns/10ps
`default_nettype none
module ihc_sync2 (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic async_in,
    output var  logic sync_out
);
    logic meta_ff;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            meta_ff  <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            meta_ff  <= async_in;
            sync_out <= meta_ff;
        end
    end
endmodule : ihc_sync2
`default_nettype wire

// ===== rtl/ihc_warmup.sv
// Oscillator warm-up counter that holds the clock after STOP is left.
`include "ihc_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module ihc_warmup #(
    parameter int unsigned CYCLES = `IHC_WARMUP_CYCLES
) (
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic start,
    output logic      done
);
    logic [20:0] cnt_ff;
    logic        run_ff;

    assign done = run_ff && (cnt_ff == 21'h000000);

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_ff <= 21'h000000;
            run_ff <= 1'b0;
        end
        else if (start)
        begin
            cnt_ff <= 21'(CYCLES - 1);
            run_ff <= 1'b1;
        end
        else if (done)
            run_ff <= 1'b0;
        else if (run_ff)
            cnt_ff <= cnt_ff - 21'h000001;
    end
endmodule : ihc_warmup
`default_nettype wire

// ===== dv/ihc_src_model.sv
// Model of the interrupt 0 source and of the CPU that answers requests.
`timescale 1ns/10ps
`default_nettype none
module ihc_src_model (
    input  wire logic       sys_clk,
    input  wire logic       rst,
    input  wire logic       raise,
    input  wire logic       drop,
    input  wire logic       slow,
    input  wire logic       cpu_irq_req,
    input  wire logic       cpu_exec_stop,
    output logic            ext0_pin,
    output logic            irq_ack,
    output logic [1:0]      irq_ack_chan
);
    logic [2:0] wait_ff;
    logic [1:0] post_ff;
    logic       acked_ff;
    wire        resp_busy;
    wire        may_drop;

    // ========================================================
    // Line hold and answer
    // ========================================================
    // The line only falls once no request is left unanswered, any answer is over and halt has ended.
    assign resp_busy    = acked_ff ? (post_ff != 2'h0) : cpu_irq_req;
    assign may_drop     = drop && !cpu_exec_stop && !resp_busy;
    assign irq_ack_chan = 2'h0;

    always_ff @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            ext0_pin <= 1'b0;
            irq_ack  <= 1'b0;
            acked_ff <= 1'b0;
            wait_ff  <= 3'h0;
            post_ff  <= 2'h0;
        end
        else
        begin
            irq_ack <= 1'b0;
            if (post_ff != 2'h0)
                post_ff <= post_ff - 2'h1;
            if (raise)
            begin
                ext0_pin <= 1'b1;
                acked_ff <= 1'b0;
                wait_ff  <= 3'h0;
            end
            else if (cpu_irq_req && ext0_pin && !acked_ff)
            begin
                wait_ff <= wait_ff + 3'h1;
                if (wait_ff == (slow ? 3'h4 : 3'h0))
                begin
                    irq_ack  <= 1'b1;
                    acked_ff <= 1'b1;
                    post_ff  <= 2'h2;
                end
            end
            else if (may_drop)
                ext0_pin <= 1'b0;
        end
    end
endmodule : ihc_src_model
`default_nettype wire

// ===== dv/irq_exceptions_halt_ctrl_tb_top.sv
// Self-checking testbench of the interrupt exception and halt block.
`timescale 1ns/10ps
`default_nettype none
`include "ihc_defines.svh"
module irq_exceptions_halt_ctrl_tb_top;
    localparam int WARM = 8;
    logic        sys_clk;
    logic        rst;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic [9:0]  ev;
    logic        cpu_en;
    logic        raise;
    logic        drop;
    logic        slow;
    logic [31:0] rd;
    int          n_fail;
    int          comparisons;
    int          k;
    int          n;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    wire         ext0_pin;
    wire         irq_ack;
    wire  [1:0]  irq_ack_chan;
    wire         cpu_irq_req;
    wire         cpu_exec_stop;
    wire         osc_stop;
    wire         sys_clk_hold;
    wire         pin_drive_en;

    ihc_ctrl #(.WARMUP_CYCLES(WARM)) i_dut (
        .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .ext0_pin(ext0_pin), .capture_set(ev[0]),
        .capture_fifo_drained(ev[1]), .gen_set(ev[2]),
        .gen_fifo_write(ev[3]), .serial_ch0_set(ev[4]),
        .serial_ch1_set(ev[5]), .serial_rx_read(ev[6]), .vass_set(ev[7]),
        .ext_irq_two_set(ev[8]), .halt_exec(ev[9]),
        .cpu_irq_enable_flag(cpu_en), .irq_ack(irq_ack),
        .irq_ack_chan(irq_ack_chan), .cpu_irq_req(cpu_irq_req),
        .cpu_exec_stop(cpu_exec_stop), .osc_stop(osc_stop),
        .sys_clk_hold(sys_clk_hold), .pin_drive_en(pin_drive_en));

    ihc_src_model i_src (
        .sys_clk(sys_clk), .rst(rst), .raise(raise), .drop(drop),
        .slow(slow), .cpu_irq_req(cpu_irq_req),
        .cpu_exec_stop(cpu_exec_stop), .ext0_pin(ext0_pin),
        .irq_ack(irq_ack), .irq_ack_chan(irq_ack_chan));

    // ========================================================
    // Helpers
    // ========================================================
    function automatic logic [31:0] byte_addr(input logic [15:0] idx);
        return {14'h0000, idx, 2'h0};
    endfunction : byte_addr

    task automatic wrap_up;
        if (n_fail == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : wrap_up

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask : check

    task automatic chk_bit(input logic got, input logic exp);
        check({31'h0, got}, {31'h0, exp});
    endtask : chk_bit

    // Waits are bounded so a stuck slave shows up as a counted failure.
    task automatic hready_wait;
        int c;
        c = 0;
        @(posedge sys_clk);
        while (hreadyout !== 1'b1 && c < 50)
        begin
            @(posedge sys_clk);
            c++;
        end
        if (c >= 50)
            n_fail++;
    endtask : hready_wait

    task automatic bus(input logic wr, input logic [15:0] idx,
                       input logic [31:0] wd, output logic [31:0] rv);
        @(posedge sys_clk);
        hsel   <= 1'b1;
        haddr  <= byte_addr(idx);
        hwrite <= wr;
        htrans <= 2'h2;
        hready_wait();
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= wd;
        hready_wait();
        rv = hrdata;
    endtask : bus

    task automatic wr(input logic [15:0] idx, input logic [31:0] d);
        logic [31:0] v;
        bus(1'b1, idx, d, v);
    endtask : wr

    task automatic rd_chk(input logic [15:0] idx, input logic [31:0] e);
        logic [31:0] v;
        bus(1'b0, idx, 32'h0, v);
        check(v, e);
    endtask : rd_chk

    task automatic pulse(input logic [9:0] m);
        @(posedge sys_clk);
        ev <= m;
        @(posedge sys_clk);
        ev <= 10'h000;
        #1;
    endtask : pulse

    task automatic pin(input logic up);
        @(posedge sys_clk);
        raise <= up;
        drop  <= !up;
        @(posedge sys_clk);
        raise <= 1'b0;
        repeat (4) @(posedge sys_clk);
    endtask : pin

    // ========================================================
    // Clock, watchdog and main sequence
    // ========================================================
    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    initial
    begin
        #(25 * 20000);
        n_fail++;
        wrap_up();
    end

    initial
    begin
        rst = 1'b1; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0;
        hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0; ev = 10'h000;
        cpu_en = 1'b0; raise = 1'b0; drop = 1'b1; slow = 1'b0;
        n_fail = 0; comparisons = 0;
        rd = $urandom(32);
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(`IHC_IDX_HALT_MODE, 32'h0);
        rd_chk(16'h0100, 32'h0);
        wr(`IHC_IDX_IRQ_EN, 32'h0F);
        repeat (12)
        begin
            k = $urandom % 4;
            pulse(k == 2 ? 10'h004 : 10'h001);
            rd_chk(`IHC_IDX_REQ_STAT, 32'h2);
            case (k)
                0: pulse(10'h002);
                1: wr(`IHC_IDX_SERVO_FLAG, 32'h1);
                2: pulse(10'h008);
                default: wr(`IHC_IDX_VEC_CLR, {24'h0, `IHC_VCODE_CAP});
            endcase
            rd_chk(`IHC_IDX_REQ_STAT, 32'h0);
        end
        pulse(10'h020);
        wr(`IHC_IDX_VEC_CLR, {24'h0, `IHC_VCODE_SIO});
        rd_chk(`IHC_IDX_REQ_STAT, 32'h4);
        rd_chk(`IHC_IDX_SIO_FLAG, 32'h6);
        rd_chk(`IHC_IDX_SIO_FLAG, 32'h0);
        pulse(10'h010);
        pulse(10'h040);
        rd_chk(`IHC_IDX_REQ_STAT, 32'h0);
        pulse(10'h080);
        wr(`IHC_IDX_SRC_SEL, 32'h8);
        rd_chk(`IHC_IDX_REQ_STAT, 32'h0);
        pulse(10'h100);
        rd_chk(`IHC_IDX_REQ_STAT, 32'h8);
        wr(`IHC_IDX_SRC_SEL, 32'h0);
        rd_chk(`IHC_IDX_REQ_STAT, 32'h0);
        pin(1'b1);
        rd_chk(`IHC_IDX_REQ_STAT, 32'h1);
        pin(1'b0);
        rd_chk(`IHC_IDX_REQ_STAT, 32'h0);
        wr(`IHC_IDX_EXT0_MODE, 32'h20);
        pin(1'b1);
        pin(1'b0);
        rd_chk(`IHC_IDX_REQ_STAT, 32'h1);
        wr(`IHC_IDX_EXT0_MODE, 32'h0);
        rd_chk(`IHC_IDX_REQ_STAT, 32'h0);
        pin(1'b1);
        wr(`IHC_IDX_EXT0_MODE, 32'h20);
        pin(1'b0);
        rd_chk(`IHC_IDX_REQ_STAT, 32'h1);
        wr(`IHC_IDX_EXT0_MODE, 32'h20);
        rd_chk(`IHC_IDX_REQ_STAT, 32'h0);
        wr(`IHC_IDX_EXT0_MODE, 32'h0);
        pulse(10'h200);
        chk_bit(cpu_exec_stop, 1'b1);
        chk_bit(osc_stop, 1'b0);
        rd_chk(`IHC_IDX_HALT_STAT, 32'h1);
        pulse(10'h001);
        repeat (3) @(posedge sys_clk);
        #1;
        chk_bit(cpu_exec_stop, 1'b0);
        rd_chk(`IHC_IDX_REQ_STAT, 32'h2);
        pulse(10'h200);
        repeat (2) @(posedge sys_clk);
        #1;
        chk_bit(cpu_exec_stop, 1'b0);
        wr(`IHC_IDX_VEC_CLR, {24'h0, `IHC_VCODE_CAP});
        wr(`IHC_IDX_HALT_MODE, 32'h05);
        pulse(10'h200);
        chk_bit(osc_stop, 1'b1);
        chk_bit(sys_clk_hold, 1'b1);
        chk_bit(pin_drive_en, 1'b1);
        @(posedge sys_clk);
        raise <= 1'b1;
        drop  <= 1'b1;
        @(posedge sys_clk);
        raise <= 1'b0;
        n = 0;
        while (osc_stop === 1'b1 && n < 20)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        n = 0;
        while (sys_clk_hold === 1'b1 && n < 40)
        begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk_bit(n >= WARM && n <= WARM + 2, 1'b1);
        #1;
        chk_bit(cpu_exec_stop, 1'b0);
        repeat (6) @(posedge sys_clk);
        wr(`IHC_IDX_HALT_MODE, 32'h0);
        cpu_en <= 1'b1;
        slow   <= 1'b1;
        pulse(10'h200);
        raise <= 1'b1;
        @(posedge sys_clk);
        raise <= 1'b0;
        n = 0;
        while (irq_ack !== 1'b1 && n < 30)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk_bit(n < 30, 1'b1);
        chk_bit(cpu_irq_req, 1'b1);
        chk_bit(cpu_exec_stop, 1'b0);
        chk_bit(hresp, 1'b0);
        repeat (8) @(posedge sys_clk);
        cpu_en <= 1'b0;
        wrap_up();
    end
endmodule : irq_exceptions_halt_ctrl_tb_top
`default_nettype wire
